// >>> hdl/adcscp_defines.svh
/*
 * timing counts, field widths and reset values for the serial control
 * port. assumes a 125 MHz system clock sampling the link pins.
 */
`ifndef ADCSCP_DEFINES_SVH
`define ADCSCP_DEFINES_SVH

// ************************************************************
// widths and reset values
// ************************************************************
`define ADCSCP_WORD_W       16
`define ADCSCP_CFG_RESET    16'h0000
`define ADCSCP_FIFO_DEPTH   8

// ************************************************************
// timing
// ************************************************************
`define ADCSCP_CLK_NS       8
`define ADCSCP_CONV_NS      1000
`define ADCSCP_CONV_CYC     ((`ADCSCP_CONV_NS) / (`ADCSCP_CLK_NS))

`endif

// >>> hdl/adcscp_pkg.sv
/*
 * types shared by the serial control port.
 * assumes adcscp_defines.svh is on the include path.
 */
`include "adcscp_defines.svh"

package adcscp_pkg;
   typedef logic [`ADCSCP_WORD_W-1:0] adcscp_word_t;

   typedef enum logic [1:0] {
      ADCSCP_IDLE  = 2'b00,
      ADCSCP_CONV  = 2'b01,
      ADCSCP_SLEEP = 2'b10
   } adcscp_state_e;
endpackage

// >>> hdl/adcscp_fifo.sv
/*
 * small flip-flop fifo with valid/ready on both sides.
 * assumes a single clock and an asynchronous active-high reset.
 */
`timescale 1ns/10ps

module adcscp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // fill side
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   // drain side
   output logic                  out_valid_out,
   output logic [WIDTH-1:0]      out_data_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_reg;
   logic [AW-1:0]    rd_reg;
   logic [AW:0]      cnt_reg;
   logic             push;
   logic             pop;

   assign in_ready_out  = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid_out = (cnt_reg != '0);
   assign out_data_out  = mem_reg[rd_reg];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   a_fifo_no_over: assert property (@(posedge clk_in) disable iff (rst_in)
      (cnt_reg == (AW+1)'(DEPTH)) |-> !push)
      else $error("fifo written while full");

endmodule // adcscp_fifo

// >>> hdl/adcscp_port.sv
/*
 * serial control port of a data acquisition converter: configuration
 * shift-in, staged configuration, conversion timing, result shift-out,
 * reset and power-down. assumes all link pins are asynchronous to clk_in
 * and that a conversion result word arrives from the converter core.
 */
// ************************************************************
// Overview of operation
// ************************************************************
// Overview of operation
// RL1: the serial port writes and reads only while select_n is low.
// RL2: the host may tie select_n low or to convert_start on a private bus; the code loads results for shift-out only while select_n is high.
// RL3: a 16-bit configuration word is shifted in on serial clock rises.
// RL4: the staged word becomes active as busy falls at end of conversion.
// RL5: configuration writes are taken both during and after conversion.
// RL6: a rising edge on the reset pin resets the port without the link clock.
// RL7: reset aborts a running conversion and restores the default config.
// RL8: a rising edge on power_down puts the converter into low power.
// RL9: the host holds power_down high until use, then waits 100 ms.
// RL10: the host discards two dummy conversions after that wait.
// RL11: serial data in and out are timed only by the host serial clock.
// RL12: results leave in twos complement, changing on serial clock falls.
// RL13: each rising edge of convert_start begins a conversion; the code ignores rises while converting or in low power.
// RL14: busy stays high for the whole conversion.
// RL15: a shifted word waits in a staging register until end of conversion.
`timescale 1ns/10ps

`include "adcscp_defines.svh"

module adcscp_port
   import adcscp_pkg::*;
(
   // clock and reset
   input  wire logic                      clk_in,
   input  wire logic                      rst_in,
   // link pins
   input  wire logic                      serial_clk_in,
   input  wire logic                      select_n_in,
   input  wire logic                      serial_in_in,
   input  wire logic                      convert_start_in,
   input  wire logic                      reset_pin_in,
   input  wire logic                      power_down_in,
   output logic                           serial_out_out,
   output logic                           serial_out_oe_out,
   output logic                           busy_out,
   // converter core side
   input  wire logic                      result_valid_in,
   input  wire logic [`ADCSCP_WORD_W-1:0] result_in,
   output logic                           result_ready_out,
   output logic [`ADCSCP_WORD_W-1:0]      cfg_out,
   output logic                           low_power_out
);
   localparam int CONV_CYC = `ADCSCP_CONV_CYC;

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [4:0] meta_reg;
   logic [4:0] sync_reg;
   logic [4:0] last_reg;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_reg <= 5'h1F;
         sync_reg <= 5'h1F;
         last_reg <= 5'h1F;
      end else begin
         meta_reg <= {power_down_in, reset_pin_in, convert_start_in,
                      select_n_in, serial_clk_in};
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   logic sck_rise;
   logic sck_fall;
   logic sel_active;
   logic conv_rise;
   logic rst_rise;
   logic pwrdn_rise;
   logic din_meta_reg;
   logic din_sync_reg;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         din_meta_reg <= 1'b0;
         din_sync_reg <= 1'b0;
      end else begin
         din_meta_reg <= serial_in_in;
         din_sync_reg <= din_meta_reg;
      end
   end

   // RL11 edges of host clock
   assign sck_rise   = sync_reg[0] && !last_reg[0];
   assign sck_fall   = !sync_reg[0] && last_reg[0];
   // RL1 select gating
   assign sel_active = !sync_reg[1];
   assign conv_rise  = sync_reg[2] && !last_reg[2];
   // RL6 reset pin edge
   assign rst_rise   = sync_reg[3] && !last_reg[3];
   assign pwrdn_rise = sync_reg[4] && !last_reg[4];

   // ************************************************************
   // conversion state machine
   // ************************************************************
   adcscp_state_e state_reg;
   logic [$clog2(CONV_CYC+1)-1:0] conv_cnt_reg;
   logic eoc;

   assign eoc = (state_reg == ADCSCP_CONV) && (conv_cnt_reg == '0);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg    <= ADCSCP_IDLE;
         conv_cnt_reg <= '0;
      end else if (rst_rise) begin
         // RL7 abort conversion
         state_reg    <= ADCSCP_IDLE;
         conv_cnt_reg <= '0;
      end else if (pwrdn_rise) begin
         // RL8 enter low power
         state_reg <= ADCSCP_SLEEP;
      end else begin
         case (state_reg)
            ADCSCP_IDLE: begin
               // RL13 start on rise
               if (conv_rise) begin
                  state_reg    <= ADCSCP_CONV;
                  conv_cnt_reg <= ($bits(conv_cnt_reg))'(CONV_CYC - 1);
               end
            end
            ADCSCP_CONV: begin
               if (eoc) begin
                  state_reg <= ADCSCP_IDLE;
               end else begin
                  conv_cnt_reg <= conv_cnt_reg - 1'b1;
               end
            end
            ADCSCP_SLEEP: begin
               if (!sync_reg[4]) begin
                  state_reg <= ADCSCP_IDLE;
               end
            end
            default: begin
               state_reg <= ADCSCP_IDLE;
            end
         endcase
      end
   end

   // RL14 busy during conversion
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_out <= 1'b0;
      end else begin
         busy_out <= (state_reg == ADCSCP_CONV) && !eoc && !rst_rise
                     && !pwrdn_rise || (state_reg == ADCSCP_IDLE)
                     && conv_rise && !rst_rise && !pwrdn_rise;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         low_power_out <= 1'b0;
      end else begin
         low_power_out <= (state_reg == ADCSCP_SLEEP) || pwrdn_rise;
      end
   end

   // ************************************************************
   // configuration shift-in and staging
   // ************************************************************
   adcscp_word_t shift_reg;
   adcscp_word_t stage_reg;
   logic [4:0]   bit_cnt_reg;
   logic         stage_full_reg;
   logic         word_done;

   assign word_done = sel_active && sck_rise
                      && (bit_cnt_reg == 5'(`ADCSCP_WORD_W - 1));

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         shift_reg   <= '0;
         bit_cnt_reg <= '0;
         stage_reg   <= `ADCSCP_CFG_RESET;
      end else if (rst_rise) begin
         bit_cnt_reg <= '0;
      end else if (!sel_active) begin
         bit_cnt_reg <= '0;
      end else if (sck_rise) begin
         // RL3 sample on rise
         // RL5 any conversion phase
         shift_reg <= {shift_reg[`ADCSCP_WORD_W-2:0], din_sync_reg};
         if (word_done) begin
            // RL15 stage full word
            stage_reg   <= {shift_reg[`ADCSCP_WORD_W-2:0], din_sync_reg};
            bit_cnt_reg <= '0;
         end else begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
         end
      end
   end

   // pending flag: a word finishing in the eoc cycle wins over the clear
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         stage_full_reg <= 1'b0;
      end else if (rst_rise) begin
         stage_full_reg <= 1'b0;
      end else if (word_done) begin
         stage_full_reg <= 1'b1;
      end else if (eoc) begin
         stage_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cfg_out <= `ADCSCP_CFG_RESET;
      end else if (rst_rise) begin
         // RL7 default config
         cfg_out <= `ADCSCP_CFG_RESET;
      end else if (eoc && stage_full_reg) begin
         // RL4 apply at busy fall
         cfg_out <= stage_reg;
      end
   end

   // ************************************************************
   // result path
   // ************************************************************
   logic         fifo_valid;
   adcscp_word_t fifo_data;
   logic         fifo_ready;
   logic         fifo_in_ready;
   adcscp_word_t out_reg;
   logic [4:0]   out_cnt_reg;

   adcscp_fifo #(
      .WIDTH (`ADCSCP_WORD_W),
      .DEPTH (`ADCSCP_FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .in_valid_in   (result_valid_in),
      .in_data_in    (result_in),
      .in_ready_out  (fifo_in_ready),
      .out_valid_out (fifo_valid),
      .out_data_out  (fifo_data),
      .out_ready_in  (fifo_ready)
   );

   assign fifo_ready = (out_cnt_reg == '0) && !sel_active;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         result_ready_out <= 1'b0;
      end else begin
         result_ready_out <= fifo_in_ready;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         out_reg     <= '0;
         out_cnt_reg <= '0;
      end else if (fifo_valid && fifo_ready) begin
         out_reg     <= fifo_data;
         out_cnt_reg <= 5'(`ADCSCP_WORD_W);
      end else if (sel_active && sck_fall && out_cnt_reg != '0) begin
         // RL12 change on fall
         out_reg     <= {out_reg[`ADCSCP_WORD_W-2:0], 1'b0};
         out_cnt_reg <= out_cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         serial_out_out    <= 1'b0;
         serial_out_oe_out <= 1'b0;
      end else begin
         // RL12 msb first twos complement
         serial_out_out    <= out_reg[`ADCSCP_WORD_W-1];
         // RL1 drive only when selected
         serial_out_oe_out <= sel_active;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   a_busy_length: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(busy_out) |-> busy_out [*8]) // RL14
      else $error("busy dropped too early");

   a_cfg_hold: assert property (@(posedge clk_in) disable iff (rst_in)
      !eoc && !rst_rise |=> $stable(cfg_out)) // RL15
      else $error("config changed outside end of conversion");

   a_cfg_apply: assert property (@(posedge clk_in) disable iff (rst_in)
      eoc && stage_full_reg && !rst_rise |=> cfg_out == $past(stage_reg)) // RL4
      else $error("staged config not applied");

   a_reset_pin: assert property (@(posedge clk_in) disable iff (rst_in)
      rst_rise |=> !busy_out && cfg_out == `ADCSCP_CFG_RESET) // RL7
      else $error("reset pin did not abort");

   a_conv_start: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg == ADCSCP_IDLE && conv_rise && !rst_rise && !pwrdn_rise
      |=> busy_out) // RL13
      else $error("conversion did not start");

   a_power_down: assert property (@(posedge clk_in) disable iff (rst_in)
      pwrdn_rise |=> low_power_out) // RL8
      else $error("power down not entered");

   a_sel_oe: assert property (@(posedge clk_in) disable iff (rst_in)
      sync_reg[1] |=> !serial_out_oe_out) // RL1
      else $error("output driven while deselected");

   a_shift_gate: assert property (@(posedge clk_in) disable iff (rst_in)
      !sel_active && !rst_rise |=> bit_cnt_reg == '0) // RL1
      else $error("shift counted while deselected");

endmodule // adcscp_port

// >>> verif/adcscp_host.sv
/*
 * host controller model driving the serial control port link pins.
 * assumes the host owns the serial clock, which idles low between frames.
 */
`timescale 1ns/10ps

module adcscp_host #(
   // reference wait after power-down release; benches may shorten it
   parameter int REF_WAIT_NS = 100_000_000
) (
   // link pins driven by the host
   output logic      serial_clk_out,
   output logic      select_n_out,
   output logic      serial_in_out,
   output logic      convert_start_out,
   output logic      reset_pin_out,
   output logic      power_down_out,
   // link pins driven by the device
   input  wire logic serial_out_in
);
   initial begin
      serial_clk_out    = 1'b0;
      select_n_out      = 1'b1;
      serial_in_out     = 1'b0;
      convert_start_out = 1'b0;
      reset_pin_out     = 1'b0;
      power_down_out    = 1'b0;
   end

   task automatic select(input logic en);
      select_n_out = ~en;
      #20;
   endtask

   task automatic write_word(input logic [15:0] w, input logic en);
      select(en);
      for (int i = 15; i >= 0; i--) begin
         serial_in_out = w[i];
         #62.5 serial_clk_out = 1'b1;
         #62.5 serial_clk_out = 1'b0;
      end
      #20 select_n_out = 1'b1;
      serial_in_out = ~w[0];
   endtask

   task automatic read_word(output logic [15:0] w);
      select(1'b1);
      #42.5;
      for (int i = 15; i >= 0; i--) begin
         w[i] = serial_out_in;
         serial_clk_out = 1'b1;
         #62.5 serial_clk_out = 1'b0;
         #62.5;
      end
      select_n_out = 1'b1;
   endtask

   task automatic convert();
      convert_start_out = 1'b1;
      #80 convert_start_out = 1'b0;
   endtask

   task automatic pulse_reset();
      reset_pin_out = 1'b1;
      #80 reset_pin_out = 1'b0;
   endtask

   // reference wait then two dummy conversions
   task automatic wake();
      power_down_out = 1'b0;
      #(REF_WAIT_NS);
      repeat (2) begin
         convert();
         #1500;
      end
   endtask
endmodule // adcscp_host

// >>> verif/tb_adcscp_port.sv
/*
 * self-checking bench of the serial control port with a host model.
 * assumes the design files are compiled first.
 */
`timescale 1ns/10ps

module tb_adcscp_port;
   import adcscp_pkg::*;

   logic        clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        sclk, sel_n, sdin, conv, rpin, pdn;
   logic        ser_out, ser_out_oe, ser_line;
   logic        busy_out, res_valid, res_ready, low_power;
   logic [15:0] res_data, cfg;
   int          mismatches = 0;
   int          n_compared = 0;
   int          cycles = 0;

   always #4 clk_in = ~clk_in;

   // a released output line shows the inverse so a late enable is caught
   assign ser_line = ser_out_oe ? ser_out : ~ser_out;

   adcscp_host #(.REF_WAIT_NS(400)) adcscp_host_inst (.serial_clk_out(sclk),
      .select_n_out(sel_n), .serial_in_out(sdin),
      .convert_start_out(conv), .reset_pin_out(rpin),
      .power_down_out(pdn), .serial_out_in(ser_line));

   adcscp_port adcscp_port_inst (.clk_in(clk_in), .rst_in(rst_in),
      .serial_clk_in(sclk), .select_n_in(sel_n), .serial_in_in(sdin),
      .convert_start_in(conv), .reset_pin_in(rpin),
      .power_down_in(pdn), .serial_out_out(ser_out),
      .serial_out_oe_out(ser_out_oe), .busy_out(busy_out),
      .result_valid_in(res_valid), .result_in(res_data),
      .result_ready_out(res_ready), .cfg_out(cfg),
      .low_power_out(low_power));

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_busy(input logic lvl, input int lim);
      for (int n = 0; n < lim && busy_out !== lvl; n++) begin
         @(posedge clk_in);
         #1;
      end
   endtask

   task automatic conv_wait();
      adcscp_host_inst.convert();
      wait_busy(1'b1, 30);
      check({15'h0, busy_out}, 16'h0001);
      repeat (100) @(posedge clk_in);
      check({15'h0, busy_out}, 16'h0001);
      wait_busy(1'b0, 60);
      check({15'h0, busy_out}, 16'h0000);
      #20;
   endtask

   task automatic t_stage();
      adcscp_host_inst.write_word(16'hA5C3, 1'b1);
      check(cfg, 16'h0000);
      conv_wait();
      check(cfg, 16'hA5C3);
      $display("test stage done");
   endtask

   task automatic t_during();
      adcscp_host_inst.convert();
      adcscp_host_inst.write_word(16'h3C5A, 1'b1);
      check(cfg, 16'hA5C3);
      conv_wait();
      check(cfg, 16'h3C5A);
      $display("test during done");
   endtask

   task automatic t_deselect();
      adcscp_host_inst.write_word(16'hFFFF, 1'b0);
      conv_wait();
      check(cfg, 16'h3C5A);
      $display("test deselect done");
   endtask

   task automatic t_reset_pin();
      adcscp_host_inst.convert();
      repeat (20) @(posedge clk_in);
      adcscp_host_inst.pulse_reset();
      repeat (8) @(posedge clk_in);
      check({15'h0, busy_out}, 16'h0000);
      check(cfg, 16'h0000);
      $display("test reset pin done");
   endtask

   task automatic t_power_down();
      adcscp_host_inst.power_down_out = 1'b1;
      repeat (8) @(posedge clk_in);
      check({15'h0, low_power}, 16'h0001);
      adcscp_host_inst.convert();
      repeat (10) @(posedge clk_in);
      check({15'h0, busy_out}, 16'h0000);
      adcscp_host_inst.wake();
      check({15'h0, low_power}, 16'h0000);
      $display("test power down done");
   endtask

   task automatic t_fifo();
      logic [15:0] w;
      adcscp_host_inst.select(1'b1);
      for (int i = 0; i < 9; i++) begin
         @(posedge clk_in);
         #1 res_valid = 1'b1;
         res_data = 16'h8001 + 16'(i * 16'h1111);
         for (int n = 0; n < 20 && res_ready !== 1'b1; n++) @(posedge clk_in);
         @(posedge clk_in);
         #1 res_valid = 1'b0;
      end
      check({15'h0, res_ready}, 16'h0000);
      check({15'h0, ser_out_oe}, 16'h0001);
      adcscp_host_inst.select_n_out = 1'b1;
      for (int i = 0; i < 8; i++) begin
         repeat (10) @(posedge clk_in);
         check({15'h0, ser_out_oe}, 16'h0000);
         adcscp_host_inst.read_word(w);
         check(w, 16'h8001 + 16'(i * 16'h1111));
      end
      repeat (10) @(posedge clk_in);
      check({15'h0, res_ready}, 16'h0001);
      $display("test fifo done");
   endtask

   initial begin
      res_valid = 1'b0;
      res_data  = 16'h0000;
      repeat (16) @(posedge clk_in);
      #1 rst_in = 1'b0;
      repeat (4) @(posedge clk_in);
      check(cfg, 16'h0000);
      t_stage();
      t_during();
      t_deselect();
      t_reset_pin();
      t_power_down();
      t_fifo();
      conclude();
   end
endmodule // tb_adcscp_port
